// >>> rtl/cfs_supervisor.v
// Top of the converter fault supervisor
`timescale 1ns/1ps
`include "cfs_consts.vh"
module cfs_supervisor #(
	parameter VW = 12,
	parameter MS_CYCLES = `CFS_MS_CYCLES
) (
	input wire mclk,
	input wire srst,
	input wire output_enable,
	input wire internal_6v_rail_ok,
	input wire analog_supply_input_ok,
	input wire fixed_ov_level_select,
	input wire [11:0] die_temp,
	input wire [11:0] ot_fault_limit,
	input wire [11:0] ot_warn_limit,
	input wire adc_valid,
	input wire [VW-1:0] feedback_node,
	input wire [VW-1:0] vref_mv,
	input wire [VW-1:0] ov_fault_mv,
	input wire [VW-1:0] ov_warn_mv,
	input wire [VW-1:0] uv_warn_mv,
	input wire [VW-1:0] uv_fault_mv,
	input wire [1:0] ot_resp,
	input wire ot_resp_wr,
	input wire [1:0] ov_resp,
	input wire [1:0] uv_resp,
	input wire [1:0] ton_max_resp,
	input wire [15:0] ton_max_ms,
	input wire [15:0] ton_rise_ms,
	input wire soft_start_done,
	input wire [5:0] alert_mask,
	input wire [5:0] status_clear,
	output reg switching_en_q,
	output reg high_side_off_q,
	output reg low_side_on_q,
	output reg restart_req_q,
	output reg [VW-1:0] vout_telemetry_q,
	output reg bandgap_overtemp_flag_q,
	output reg [5:0] status_q,
	output reg alert_n_o_q,
	output reg alert_n_oe_q,
	output reg power_good_output_oe_q,
	output reg power_good_output_o_q
);
	// ****************************************
	// Status bit positions
	// ****************************************
	localparam S_BGOT = 0;
	localparam S_OT = 1;
	localparam S_OTW = 2;
	localparam S_OV = 3;
	localparam S_UV = 4;
	localparam S_TONMAX = 5;
	// ****************************************
	// Converter supervision states
	// ****************************************
	localparam ST_OFF = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_RUN = 3'h2;
	localparam ST_HICCUP = 3'h3;
	localparam ST_LATCH = 3'h4;
	localparam ST_COOL = 3'h5;

	// Register holding the programmable overtemp response
	reg [1:0] ot_resp_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg bg_hot_q; // Bandgap shutdown active
	reg ot_hot_q; // Programmable overtemp active
	reg en_q; // Previous output enable
	reg [5:0] event_d; // Fault events this cycle
	reg hiccup_load;
	reg start_load;
	reg [31:0] hiccup_cycles;
	reg [31:0] start_cycles;
	wire [VW-1:0] vavg;
	wire hiccup_done;
	wire start_done;
	wire [11:0] fixed_ov_mv;
	wire [VW-1:0] prebias_mv;
	wire ov_cond;
	wire uv_cond;
	wire ovw_cond;
	wire uvw_cond;
	wire otw_cond;
	wire enable_rise;

	// ****************************************
	// Helper: choose the hiccup/latch reaction
	// ****************************************
	function [2:0] react;
		input [1:0] resp;
		begin
			if (resp == `CFS_RESP_LATCH)
				react = ST_LATCH;
			else
				react = ST_HICCUP;
		end
	endfunction

	// ****************************************
	// Telemetry and delay helpers
	// ****************************************
	cfs_averager #(.W(VW), .SH(`CFS_AVG_SHIFT)) u_avg (
		.mclk(mclk),
		.srst(srst),
		.sample_valid(adc_valid),
		.sample(feedback_node),
		.avg_q(vavg)
	);
	cfs_timer #(.W(32)) u_hiccup (
		.mclk(mclk),
		.srst(srst),
		.load(hiccup_load),
		.load_val(hiccup_cycles),
		.done_q(hiccup_done)
	);
	cfs_timer #(.W(32)) u_start (
		.mclk(mclk),
		.srst(srst),
		.load(start_load),
		.load_val(start_cycles),
		.done_q(start_done)
	);

	// ****************************************
	// Comparators
	// ****************************************
	// Fixed level by select pin
	assign fixed_ov_mv = fixed_ov_level_select ? `CFS_FIXED_OV_HI_MV : `CFS_FIXED_OV_LO_MV;
	// Regulation plus five percent
	assign prebias_mv = vref_mv + vref_mv / 7'd100 * `CFS_PREBIAS_PCT;
	// OV armed only with supply and 6V rail up
	assign ov_cond = analog_supply_input_ok && internal_6v_rail_ok &&
		((feedback_node > ov_fault_mv) || (feedback_node > fixed_ov_mv));
	assign uv_cond = feedback_node < uv_fault_mv;
	assign ovw_cond = (feedback_node > ov_warn_mv) || (feedback_node > prebias_mv);
	assign uvw_cond = feedback_node < uv_warn_mv;
	assign otw_cond = die_temp > ot_warn_limit;
	assign enable_rise = output_enable && !en_q;

	// ****************************************
	// Delay lengths in clock cycles
	// ****************************************
	always @* begin
		hiccup_cycles = ton_rise_ms * MS_CYCLES * `CFS_RESTART_RAMPS;
		start_cycles = ton_max_ms * MS_CYCLES;
	end

	// ****************************************
	// Temperature trackers with hysteresis
	// ****************************************
	always @(posedge mclk) begin
		if (srst) begin
			bg_hot_q <= 1'b0;
			ot_hot_q <= 1'b0;
			ot_resp_q <= `CFS_OT_RESP_RESET; // Ignore at power-up
			en_q <= 1'b0;
		end else begin
			en_q <= output_enable;
			if (ot_resp_wr)
				ot_resp_q <= ot_resp;
			if (die_temp > `CFS_TEMP_SHUTDOWN)
				bg_hot_q <= 1'b1;
			else if (die_temp <= `CFS_TEMP_SHUTDOWN - `CFS_TEMP_HYST)
				bg_hot_q <= 1'b0;
			if (die_temp > ot_fault_limit)
				ot_hot_q <= 1'b1;
			else if (die_temp <= ot_fault_limit - `CFS_TEMP_HYST)
				ot_hot_q <= 1'b0;
		end
	end

	// ****************************************
	// Fault state machine
	// ****************************************
	always @* begin
		state_d = state_q;
		event_d = 6'h00;
		hiccup_load = 1'b0;
		start_load = 1'b0;
		if (bg_hot_q && state_q != ST_COOL) begin
			// Never ignored, always shut down
			event_d[S_BGOT] = 1'b1;
			state_d = ST_COOL;
		end else begin
			case (state_q)
				ST_OFF: begin
					if (output_enable) begin
						state_d = ST_START;
						start_load = 1'b1;
					end
				end
				ST_START, ST_RUN: begin
					if (!output_enable) begin
						state_d = ST_OFF;
					end else if (ov_cond && ov_resp != `CFS_RESP_IGNORE) begin
						event_d[S_OV] = 1'b1;
						state_d = react(ov_resp);
						hiccup_load = 1'b1;
					end else if (ot_hot_q && ot_resp_q != `CFS_RESP_IGNORE) begin
						event_d[S_OT] = 1'b1;
						state_d = (ot_resp_q == `CFS_RESP_LATCH) ? ST_LATCH : ST_COOL;
					end else if (state_q == ST_START) begin
						// UV deferred until limit
						if (soft_start_done && !uv_cond)
							state_d = ST_RUN;
						else if (start_done && ton_max_resp != `CFS_RESP_IGNORE) begin
							event_d[S_TONMAX] = 1'b1;
							state_d = react(ton_max_resp);
							hiccup_load = 1'b1;
						end
					end else if (uv_cond && uv_resp != `CFS_RESP_IGNORE) begin
						event_d[S_UV] = 1'b1;
						state_d = react(uv_resp);
						hiccup_load = 1'b1;
					end
				end
				ST_HICCUP: begin
					if (!output_enable)
						state_d = ST_OFF;
					else if (hiccup_done) begin
						state_d = ST_START;
						start_load = 1'b1;
					end
				end
				ST_LATCH: begin
					if (enable_rise) begin
						state_d = ST_START;
						start_load = 1'b1;
					end
				end
				ST_COOL: begin
					if (!bg_hot_q && !ot_hot_q) begin
						state_d = output_enable ? ST_START : ST_OFF;
						start_load = output_enable;
					end
				end
				default: state_d = ST_OFF;
			endcase
		end
		// Events seen regardless of response
		event_d[S_OTW] = otw_cond;
		if (ov_cond)
			event_d[S_OV] = 1'b1;
		if (uv_cond && state_q == ST_RUN)
			event_d[S_UV] = 1'b1;
		if (ot_hot_q)
			event_d[S_OT] = 1'b1;
	end

	// ****************************************
	// State, status, alert and outputs
	// ****************************************
	always @(posedge mclk) begin
		if (srst) begin
			state_q <= ST_OFF;
			status_q <= 6'h00;
			bandgap_overtemp_flag_q <= 1'b0;
			switching_en_q <= 1'b0;
			high_side_off_q <= 1'b1;
			low_side_on_q <= 1'b0;
			restart_req_q <= 1'b0;
			vout_telemetry_q <= {VW{1'b0}};
			alert_n_o_q <= 1'b0;
			alert_n_oe_q <= 1'b0;
			power_good_output_o_q <= 1'b0;
			power_good_output_oe_q <= 1'b1;
		end else begin
			state_q <= state_d;
			// Set wins over clear
			status_q <= (status_q & ~status_clear) | event_d;
			bandgap_overtemp_flag_q <= (bandgap_overtemp_flag_q & ~status_clear[S_BGOT]) |
				event_d[S_BGOT];
			vout_telemetry_q <= vavg;
			// Switching only when starting or running
			switching_en_q <= (state_d == ST_START) || (state_d == ST_RUN);
			high_side_off_q <= !((state_d == ST_START) || (state_d == ST_RUN));
			// Low-side discharge during overvoltage
			low_side_on_q <= ov_cond && ov_resp != `CFS_RESP_IGNORE &&
				state_d != ST_RUN && state_d != ST_START;
			restart_req_q <= (state_d == ST_START) && (state_q != ST_START);
			// Open-drain alert pulled when unmasked flag held
			// Follows the next flag value, so a clear releases it on the same edge
			alert_n_oe_q <= |(((status_q & ~status_clear) | event_d) & ~alert_mask);
			// Power-good released inside window after startup
			power_good_output_oe_q <= !((state_d == ST_RUN) && !ovw_cond && !uvw_cond &&
				!ov_cond && !bg_hot_q && !(ot_hot_q && ot_resp_q != `CFS_RESP_IGNORE) &&
				!(otw_cond && ot_resp_q != `CFS_RESP_IGNORE));
		end
	end
endmodule

// >>> rtl/cfs_consts.vh
// Constants for the converter fault supervisor
// Operation
// - Bandgap temp above shutdown level halts conversion
// - Restart only after temperature falls by hysteresis
// - Bandgap shutdown raises alert unless masked
// - Overtemp response selectable, defaults to ignore
// - Bandgap overtemp never ignored, restarts when cooled
// - Output voltage digitized, averaged, held as telemetry
// - Overvoltage stops switching, turns low-side on
// - Overvoltage flags, alerts, then hiccups or latches
// - Overvoltage active once 6V rail passes lockout
// - Overvoltage ignore keeps switching uninterrupted
// - Undervoltage after soft-start stops, then latch/hiccup
// - Undervoltage flags and alerts; ignore continues
// - Fixed overvoltage level 2.2V or 1.4V by pin
// - Startup time limit defers undervoltage detection
// - Power-good released inside warning window after start
// - Power-good low on any fault except an overtemp whose response is ignore
// - Prebias above 5% trips warning and power-good
// - Overtemp latch, restart-after-cooling, or ignore behaviour
// - Overtemp warning alerts, pulls power-good low unless ignore
// - Restart waits seven soft-start ramp times
`ifndef CFS_CONSTS_VH
`define CFS_CONSTS_VH
// ****************************************
// Response encodings
// ****************************************
`define CFS_RESP_LATCH 2'h0
`define CFS_RESP_RESTART 2'h1
`define CFS_RESP_IGNORE 2'h2
`define CFS_OT_RESP_RESET 2'h2
// ****************************************
// Thresholds in degrees C and millivolts on feedback, prebias percent, restart ramp count
// ****************************************
`define CFS_TEMP_SHUTDOWN 12'h091
`define CFS_TEMP_HYST 12'h014
`define CFS_FIXED_OV_HI_MV 12'h898
`define CFS_FIXED_OV_LO_MV 12'h578
`define CFS_PREBIAS_PCT 12'h005
`define CFS_RESTART_RAMPS 8'h07
// ****************************************
// Timing
// ****************************************
`define CFS_CLK_KHZ 25000
`define CFS_MS_CYCLES 25000
`define CFS_AVG_SHIFT 3
`endif

// >>> rtl/cfs_averager.v
// Running-average filter for output voltage telemetry
`timescale 1ns/1ps
`include "cfs_consts.vh"
module cfs_averager #(
	parameter W = 12,
	parameter SH = `CFS_AVG_SHIFT
) (
	input wire mclk,
	input wire srst,
	input wire sample_valid,
	input wire [W-1:0] sample,
	output reg [W-1:0] avg_q
);
	// Accumulator holding 2^SH times the average
	reg [W+SH-1:0] acc_q;
	wire [W+SH-1:0] acc_d;
	// ****************************************
	// Exponential average: acc += x - acc/2^SH
	// ****************************************
	assign acc_d = acc_q + {{SH{1'b0}}, sample} - {{SH{1'b0}}, acc_q[W+SH-1:SH]};
	always @(posedge mclk) begin
		if (srst) begin
			acc_q <= {(W+SH){1'b0}};
			avg_q <= {W{1'b0}};
		end else if (sample_valid) begin // Each new sample
			acc_q <= acc_d;
			avg_q <= acc_d[W+SH-1:SH];
		end
	end
endmodule

// >>> rtl/cfs_timer.v
// Down-counter for startup limit and hiccup delays
`timescale 1ns/1ps
module cfs_timer #(
	parameter W = 32
) (
	input wire mclk,
	input wire srst,
	input wire load,
	input wire [W-1:0] load_val,
	output reg done_q
);
	// Remaining cycles
	reg [W-1:0] cnt_q;
	// ****************************************
	// Load, then count to zero
	// ****************************************
	always @(posedge mclk) begin
		if (srst) begin
			cnt_q <= {W{1'b0}};
			done_q <= 1'b0;
		end else if (load) begin
			cnt_q <= load_val;
			done_q <= 1'b0;
		end else if (cnt_q != {W{1'b0}}) begin
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			done_q <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
		end else begin
			done_q <= 1'b0;
		end
	end
endmodule

// >>> testbench/cfs_stage_model.sv
// Behavioural power stage and sensing model for the supervisor bench
`timescale 1ns/1ps
module cfs_stage_model (
	input wire mclk,
	input wire srst,
	input wire switching_en,
	input wire [11:0] level,
	output logic adc_valid,
	output logic [11:0] feedback_node,
	output logic soft_start_done
);
	logic [3:0] ramp_q; // Cycles of soft-start so far
	logic [1:0] div_q; // Sample rate divider
	// ****************************************
	// Sampling and soft-start ramp
	// ****************************************
	always @(posedge mclk) begin
		div_q <= srst ? 2'h0 : div_q + 2'h1;
		adc_valid <= (div_q == 2'h3);
		if (srst || !switching_en) begin // Ramp restarts when switching stops
			ramp_q <= 4'h0;
		end else if (ramp_q != 4'hF) begin
			ramp_q <= ramp_q + 4'h1;
		end
	end
	assign soft_start_done = (ramp_q >= 4'h8); // Ramp done after 8 cycles
	assign feedback_node = level; // Sense node follows bench level
endmodule

// >>> testbench/cfs_supervisor_properties.sv
// Concurrent checks on the fault supervisor ports
`timescale 1ns/1ps
module cfs_supervisor_properties #(
	parameter VW = 12
) (
	input wire mclk,
	input wire srst,
	input wire analog_supply_input_ok,
	input wire internal_6v_rail_ok,
	input wire [11:0] die_temp,
	input wire adc_valid,
	input wire [VW-1:0] feedback_node,
	input wire [VW-1:0] ov_fault_mv,
	input wire [1:0] ov_resp,
	input wire [1:0] uv_resp,
	input wire [5:0] alert_mask,
	input wire [5:0] status_clear,
	input wire switching_en_q,
	input wire high_side_off_q,
	input wire low_side_on_q,
	input wire [VW-1:0] vout_telemetry_q,
	input wire bandgap_overtemp_flag_q,
	input wire [5:0] status_q,
	input wire alert_n_oe_q,
	input wire power_good_output_oe_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Armed overvoltage while switching, not ignored
	sequence s_ov_seen;
		analog_supply_input_ok && internal_6v_rail_ok && switching_en_q
			&& feedback_node > ov_fault_mv && ov_resp != 2'h2;
	endsequence
	// Discharge response with flag
	sequence s_ov_resp;
		!switching_en_q && low_side_on_q && status_q[3];
	endsequence
	AST_BG_TRIP: assert property (die_temp > 12'h091 |-> ##2 !switching_en_q && bandgap_overtemp_flag_q && status_q[0])
		else $error("bandgap trip missed");
	AST_BG_HOLD: assert property (bandgap_overtemp_flag_q && die_temp > 12'h07D |=> !switching_en_q)
		else $error("restart before cooling");
	AST_BG_ALERT: assert property ($rose(status_q[0]) && !alert_mask[0] |-> alert_n_oe_q)
		else $error("bandgap alert missing");
	AST_OV_TRIP: assert property (s_ov_seen |=> s_ov_resp)
		else $error("overvoltage response missing");
	AST_OV_STICKY: assert property (status_q[3] && !status_clear[3] |=> status_q[3])
		else $error("overvoltage flag lost");
	AST_UV_OFF: assert property ($rose(status_q[4]) && uv_resp != 2'h2 |-> !switching_en_q && high_side_off_q && !low_side_on_q)
		else $error("undervoltage switches not off");
	AST_PG_LOW: assert property (!switching_en_q |-> power_good_output_oe_q)
		else $error("power good released while stopped");
	AST_TELEM: assert property ($changed(vout_telemetry_q) |-> $past(adc_valid, 2))
		else $error("telemetry changed without sample");
endmodule

// >>> testbench/cfs_supervisor_tb_top.sv
// Self-checking bench for the converter fault supervisor
`timescale 1ns/1ps
module cfs_supervisor_tb_top;
	logic mclk = 1'b0, srst = 1'b1, output_enable = 1'b0, ot_resp_wr = 1'b0;
	logic internal_6v_rail_ok = 1'b1, analog_supply_input_ok = 1'b1, fixed_ov_level_select = 1'b1;
	logic [11:0] die_temp = 12'h019, ot_fault_limit = 12'h0C8, ot_warn_limit = 12'h0B4;
	logic [11:0] level = 12'h3E8, vref_mv = 12'h3E8, ov_fault_mv = 12'h47E, ov_warn_mv = 12'h44C;
	logic [11:0] uv_warn_mv = 12'h384, uv_fault_mv = 12'h352;
	logic [1:0] ot_resp = 2'h2, ov_resp = 2'h1, uv_resp = 2'h1, ton_max_resp = 2'h0;
	logic [15:0] ton_max_ms = 16'h000A, ton_rise_ms = 16'h0002;
	logic [5:0] alert_mask = 6'h00, status_clear = 6'h00;
	logic adc_valid, soft_start_done, switching_en_q, high_side_off_q, low_side_on_q;
	logic restart_req_q, bandgap_overtemp_flag_q, alert_n_o_q, alert_n_oe_q;
	logic power_good_output_oe_q, power_good_output_o_q;
	logic [11:0] feedback_node, vout_telemetry_q;
	logic [5:0] status_q;
	int miscompares = 0, num_checks = 0, cycles = 0;
	// ****************************************
	// Clock, timeout, instances
	// ****************************************
	initial begin
		forever #20 mclk = ~mclk;
	end
	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_sim();
		end
	end
	cfs_stage_model i_cfs_stage_model (.mclk, .srst, .switching_en(switching_en_q), .level,
		.adc_valid, .feedback_node, .soft_start_done);
	cfs_supervisor #(.MS_CYCLES(4)) i_cfs_supervisor (.mclk, .srst, .output_enable,
		.internal_6v_rail_ok, .analog_supply_input_ok, .fixed_ov_level_select, .die_temp,
		.ot_fault_limit, .ot_warn_limit, .adc_valid, .feedback_node, .vref_mv, .ov_fault_mv,
		.ov_warn_mv, .uv_warn_mv, .uv_fault_mv, .ot_resp, .ot_resp_wr, .ov_resp, .uv_resp,
		.ton_max_resp, .ton_max_ms, .ton_rise_ms, .soft_start_done, .alert_mask, .status_clear,
		.switching_en_q, .high_side_off_q, .low_side_on_q, .restart_req_q, .vout_telemetry_q,
		.bandgap_overtemp_flag_q, .status_q, .alert_n_o_q, .alert_n_oe_q,
		.power_good_output_oe_q, .power_good_output_o_q);
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (miscompares == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Toggle enable, then wait into regulation
	task automatic power_up;
		output_enable = 1'b0;
		tick(2);
		output_enable = 1'b1;
		tick(20);
	endtask
	// Clear all sticky status bits
	task automatic clr;
		status_clear = 6'h3F;
		tick(1);
		status_clear = 6'h00;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_bandgap;
		power_up();
		chk(power_good_output_oe_q, 0);
		die_temp = 12'h092;
		tick(2);
		chk(status_q[0], 1);
		chk(alert_n_oe_q, 1);
		die_temp = 12'h07E;
		tick(3);
		chk(switching_en_q, 0);
		die_temp = 12'h07D;
		tick(8);
		chk(switching_en_q, 1);
		clr();
		chk(alert_n_oe_q, 0);
	endtask
	task automatic t_ot;
		ot_fault_limit = 12'h064;
		ot_warn_limit = 12'h05A;
		die_temp = 12'h06E;
		tick(3);
		chk(switching_en_q, 1);
		chk(power_good_output_oe_q, 0);
		ot_resp = 2'h0;
		ot_resp_wr = 1'b1;
		tick(1);
		ot_resp_wr = 1'b0;
		tick(2);
		chk({switching_en_q, high_side_off_q, low_side_on_q}, 3'h2);
		die_temp = 12'h019;
		tick(5);
		chk(switching_en_q, 0);
		power_up();
		chk(switching_en_q, 1);
		clr();
	endtask
	task automatic t_ov;
		level = 12'h4B0;
		tick(2);
		chk({switching_en_q, low_side_on_q, status_q[3], alert_n_oe_q}, 4'h7);
		level = 12'h3E8;
		tick(46);
		chk(switching_en_q, 0);
		tick(14);
		chk(switching_en_q, 1);
		clr();
		ov_resp = 2'h2;
		level = 12'h4B0;
		tick(4);
		chk(switching_en_q, 1);
		level = 12'h3E8;
		ov_resp = 2'h1;
		clr();
	endtask
	task automatic t_ov_fixed;
		internal_6v_rail_ok = 1'b0;
		level = 12'h5DC;
		tick(3);
		chk(switching_en_q, 1);
		internal_6v_rail_ok = 1'b1;
		ov_fault_mv = 12'hFFF;
		alert_mask = 6'h08;
		tick(3);
		chk(switching_en_q, 1);
		fixed_ov_level_select = 1'b0;
		tick(2);
		chk({switching_en_q, alert_n_oe_q, power_good_output_oe_q}, 3'h1);
		level = 12'h3E8;
		fixed_ov_level_select = 1'b1;
		ov_fault_mv = 12'h47E;
		alert_mask = 6'h00;
		tick(70);
		clr();
	endtask
	task automatic t_uv;
		uv_resp = 2'h0;
		level = 12'h320;
		tick(2);
		chk({switching_en_q, high_side_off_q, low_side_on_q, status_q[4]}, 4'h5);
		level = 12'h3E8;
		tick(80);
		chk(switching_en_q, 0);
		power_up();
		clr();
		uv_resp = 2'h2;
		level = 12'h320;
		tick(4);
		chk(switching_en_q, 1);
		uv_resp = 2'h1;
		output_enable = 1'b0;
		tick(2);
		output_enable = 1'b1;
		tick(20);
		chk(switching_en_q, 1);
		tick(30);
		chk({switching_en_q, status_q[5]}, 2'h1);
		level = 12'h3E8;
		output_enable = 1'b0;
		tick(400);
		chk(vout_telemetry_q >= 12'h3E0 && vout_telemetry_q <= 12'h3E8, 1);
	endtask
	initial begin
		tick(12);
		srst = 1'b0;
		tick(1);
		chk({switching_en_q, high_side_off_q, status_q, power_good_output_oe_q}, 9'h081);
		t_bandgap();
		t_ot();
		t_ov();
		t_ov_fixed();
		t_uv();
		end_sim();
	end
endmodule
bind cfs_supervisor cfs_supervisor_properties #(.VW(VW)) i_cfs_supervisor_properties (.mclk,
	.srst, .analog_supply_input_ok, .internal_6v_rail_ok, .die_temp, .adc_valid, .feedback_node,
	.ov_fault_mv, .ov_resp, .uv_resp, .alert_mask, .status_clear, .switching_en_q,
	.high_side_off_q, .low_side_on_q, .vout_telemetry_q, .bandgap_overtemp_flag_q, .status_q,
	.alert_n_oe_q, .power_good_output_oe_q);
